// >>> tws_pkg.sv
// Behaviour
// [R01] match upper seven address bits; broadcast if enabled
// [R02] software enables interface and ack, no start/stop
// [R03] own address plus read bit enters transmit
// [R04] read address acknowledged: flag set, status 0xa8
// [R05] lost arbitration then read-addressed: status 0xb0
// [R06] load byte, clear flag, send, expect ack
// [R07] ack enable zero: byte is final one
// [R08] byte sent, ack received: status 0xb8
// [R09] byte sent, nack received: status 0xc0
// [R10] final byte acknowledged anyway: status 0xc8
// [R11] after final byte release data, ignore clocks
// [R12] clearing flag leaves addressed mode
// [R13] start request served once bus free; the code serves it only at a stop seen in TWS_IDLE
// [R14] ack enable zero hides own address
// [R15] sleep: still answer address, wake part
// [R16] after wake hold clock low until flag clear
// [R17] data register not guaranteed after wake
// [R18] flag cleared only by writing one
// [R19] software masks prescaler bits of status
// [R20] interrupt while flag set and enabled
package tws_pkg;
  localparam logic [3:0] TWS_ADR_OWN    = 4'h0;
  localparam logic [3:0] TWS_ADR_CTRL   = 4'h4;
  localparam logic [3:0] TWS_ADR_STATUS = 4'h8;
  localparam logic [3:0] TWS_ADR_DATA   = 4'hc;
  localparam logic [7:0] TWS_OWN_RST    = 8'hfe;
  localparam logic [7:0] TWS_CTRL_RST   = 8'h00;
  localparam logic [7:0] TWS_DATA_RST   = 8'hff;
  localparam int TWS_B_FLAG  = 7;
  localparam int TWS_B_ACK   = 6;
  localparam int TWS_B_BEGIN = 5;
  localparam int TWS_B_END   = 4;
  localparam int TWS_B_WCOL  = 3;
  localparam int TWS_B_EN    = 2;
  localparam int TWS_B_IRQEN = 0;
  localparam logic [7:0] TWS_ST_ADDR_R   = 8'ha8;
  localparam logic [7:0] TWS_ST_ARB_R    = 8'hb0;
  localparam logic [7:0] TWS_ST_DATA_ACK = 8'hb8;
  localparam logic [7:0] TWS_ST_DATA_NAK = 8'hc0;
  localparam logic [7:0] TWS_ST_LAST_ACK = 8'hc8;
  localparam logic [7:0] TWS_ST_NONE     = 8'hf8;
  localparam logic [7:0] TWS_BROADCAST   = 8'h00;
  typedef enum {
    TWS_IDLE, TWS_ADDR, TWS_ADDR_ACK, TWS_WAIT, TWS_SEND, TWS_GET_ACK, TWS_IGNORE
  } tws_state_t;
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic scl;
  } tws_line_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] adr;
    logic [7:0] wdat;
  } tws_acc_t;
endpackage

// >>> tws_line_sync.sv
`timescale 1ns/100ps
module tws_line_sync (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output tws_pkg::tws_line_t     line_o
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_p;
    logic       sda_p;
  } tws_sync_t;
  tws_sync_t s_q;
  tws_sync_t s_d;
  always_comb
  begin
    s_d       = s_q;
    s_d.scl_s = {s_q.scl_s[0], scl_i};
    s_d.sda_s = {s_q.sda_s[0], sda_i};
    s_d.scl_p = s_q.scl_s[1];
    s_d.sda_p = s_q.sda_s[1];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '1;
    else
      s_q <= s_d;
  end
  assign line_o.scl      = s_q.scl_s[1];
  assign line_o.sda      = s_q.sda_s[1];
  assign line_o.scl_rise = s_q.scl_s[1] & ~s_q.scl_p;
  assign line_o.scl_fall = ~s_q.scl_s[1] & s_q.scl_p;
  assign line_o.start    = s_q.scl_s[1] & s_q.scl_p & s_q.sda_p & ~s_q.sda_s[1];
  assign line_o.stop     = s_q.scl_s[1] & s_q.scl_p & ~s_q.sda_p & s_q.sda_s[1];
endmodule // tws_line_sync

// >>> tws_wb_regs.sv
`timescale 1ns/100ps
module tws_wb_regs (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [3:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic [7:0]        own_i,
  input  wire logic [7:0]        ctrl_i,
  input  wire logic [7:0]        status_i,
  input  wire logic [7:0]        data_i,
  output tws_pkg::tws_acc_t      acc_o
);
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tws_bus_t;
  tws_bus_t b_q;
  tws_bus_t b_d;
  logic     req;
  logic     take;
  assign req  = cyc_i & stb_i & ~b_q.ack;
  // writes land at the edge where the master samples ack high
  assign take = cyc_i & stb_i & b_q.ack;
  always_comb
  begin
    b_d     = b_q;
    b_d.ack = req;
    b_d.dat = 32'h0000_0000;
    if (req && !we_i)
    begin
      unique case (adr_i)
        tws_pkg::TWS_ADR_OWN:    b_d.dat = {24'h00_0000, own_i};
        tws_pkg::TWS_ADR_CTRL:   b_d.dat = {24'h00_0000, ctrl_i};
        tws_pkg::TWS_ADR_STATUS: b_d.dat = {24'h00_0000, status_i};
        tws_pkg::TWS_ADR_DATA:   b_d.dat = {24'h00_0000, data_i};
        default:                 b_d.dat = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      b_q <= '0;
    else
      b_q <= b_d;
  end
  assign dat_o      = b_q.dat;
  assign ack_o      = b_q.ack;
  assign acc_o.wr   = take & we_i & sel_i[0];
  assign acc_o.rd   = take & ~we_i;
  assign acc_o.adr  = adr_i;
  assign acc_o.wdat = dat_i[7:0];
endmodule // tws_wb_regs

// >>> tws_slave_tx.sv
`timescale 1ns/100ps
module tws_slave_tx (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic        sleep_i,
  input  wire logic        arb_lost_i,
  output logic             wake_o,
  output logic             irq_o,
  output logic             begin_pending_o
);
  typedef struct packed {
    tws_pkg::tws_state_t st;
    logic [7:0]          own;
    logic [7:0]          ctrl;
    logic [7:0]          status;
    logic [7:0]          data;
    logic [7:0]          shift;
    logic [3:0]          cnt;
    logic                last;
    logic                sda_low;
    logic                hold;
    logic                slept;
    logic                arb;
    logic                begin_pend;
    logic                wake;
  } tws_core_t;
  tws_core_t          c_q;
  tws_core_t          c_d;
  tws_pkg::tws_line_t line;
  tws_pkg::tws_acc_t  acc;
  logic               flag;
  logic               ack_en;
  logic               en;
  logic               addr_hit;
  logic               clear_flag;

  //////////////////////////////////////////////////////////////////////////////
  tws_line_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .scl_i  (scl_i),
    .sda_i  (sda_i),
    .line_o (line)
  );

  tws_wb_regs u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .adr_i    (adr_i),
    .sel_i    (sel_i),
    .dat_i    (dat_i),
    .dat_o    (dat_o),
    .ack_o    (ack_o),
    .own_i    (c_q.own),
    .ctrl_i   (c_q.ctrl),
    .status_i (c_q.status),
    .data_i   (c_q.data),
    .acc_o    (acc)
  );

  //////////////////////////////////////////////////////////////////////////////
  assign flag   = c_q.ctrl[tws_pkg::TWS_B_FLAG];
  assign ack_en = c_q.ctrl[tws_pkg::TWS_B_ACK];
  assign en     = c_q.ctrl[tws_pkg::TWS_B_EN];
  // own address or enabled broadcast, only while acknowledging
  assign addr_hit = ack_en &&                                            // [R14]
                    ((c_q.shift[7:1] == c_q.own[7:1]) ||                 // [R01]
                     (c_q.shift[7:1] == tws_pkg::TWS_BROADCAST[7:1] && c_q.own[0]));
  assign clear_flag = acc.wr && acc.adr == tws_pkg::TWS_ADR_CTRL &&
                      acc.wdat[tws_pkg::TWS_B_FLAG];                     // [R18]

  always_comb
  begin
    c_d = c_q;
    // register writes
    if (acc.wr)
    begin
      unique case (acc.adr)
        tws_pkg::TWS_ADR_OWN:
          c_d.own = acc.wdat;
        tws_pkg::TWS_ADR_CTRL:
        begin
          c_d.ctrl[6:4] = acc.wdat[6:4];
          c_d.ctrl[2]   = acc.wdat[2];
          c_d.ctrl[0]   = acc.wdat[0];
          if (!acc.wdat[tws_pkg::TWS_B_WCOL])
            c_d.ctrl[tws_pkg::TWS_B_WCOL] = 1'b0;
          if (acc.wdat[tws_pkg::TWS_B_FLAG])
            c_d.ctrl[tws_pkg::TWS_B_FLAG] = 1'b0;                        // [R18]
        end
        tws_pkg::TWS_ADR_DATA:
        begin
          if (flag)
            c_d.data = acc.wdat;                                         // [R06]
          else
            c_d.ctrl[tws_pkg::TWS_B_WCOL] = 1'b1;
        end
        default:
          c_d.own = c_q.own;
      endcase
    end
    if (clear_flag)
    begin
      c_d.status = tws_pkg::TWS_ST_NONE;
      c_d.hold   = 1'b0;                                                 // [R16]
      c_d.wake   = 1'b0;
      if (acc.wdat[tws_pkg::TWS_B_BEGIN])
        c_d.begin_pend = 1'b1;                                           // [R13]
    end
    // start request served at a stop seen while the engine is in TWS_IDLE
    if (c_q.begin_pend && line.stop && c_q.st == tws_pkg::TWS_IDLE)
      c_d.begin_pend = 1'b0;                                             // [R13]
    if (arb_lost_i)
      c_d.arb = 1'b1;

    // serial engine
    if (!en)
    begin
      c_d.st      = tws_pkg::TWS_IDLE;
      c_d.sda_low = 1'b0;
    end
    else if (line.start)
    begin
      c_d.st      = tws_pkg::TWS_ADDR;
      c_d.cnt     = 4'h0;
      c_d.sda_low = 1'b0;
    end
    else if (line.stop)
    begin
      c_d.st      = tws_pkg::TWS_IDLE;
      c_d.sda_low = 1'b0;
      c_d.arb     = 1'b0;
    end
    else
    begin
      unique case (c_q.st)
        tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNORE:
          c_d.sda_low = 1'b0;                                            // [R11]
        tws_pkg::TWS_ADDR:
        begin
          if (line.scl_rise)
          begin
            c_d.shift = {c_q.shift[6:0], line.sda};
            c_d.cnt   = c_q.cnt + 4'h1;
          end
          if (line.scl_fall && c_q.cnt == 4'h8)
          begin
            // read bit selects transmit; a write or foreign address goes to TWS_IGNORE
            if (addr_hit && c_q.shift[0])                                // [R03]
            begin
              c_d.st      = tws_pkg::TWS_ADDR_ACK;
              c_d.sda_low = 1'b1;                                        // [R15]
              if (sleep_i)
              begin
                c_d.wake  = 1'b1;                                        // [R15]
                c_d.slept = 1'b1;
              end
            end
            else
              c_d.st = tws_pkg::TWS_IGNORE;
          end
        end
        tws_pkg::TWS_ADDR_ACK:
        begin
          if (line.scl_fall)
          begin
            c_d.sda_low = 1'b0;
            c_d.st      = tws_pkg::TWS_WAIT;
            c_d.hold    = 1'b1;
            c_d.ctrl[tws_pkg::TWS_B_FLAG] = 1'b1;
            c_d.status  = c_q.arb ? tws_pkg::TWS_ST_ARB_R                // [R05]
                                  : tws_pkg::TWS_ST_ADDR_R;              // [R04]
            c_d.arb     = 1'b0;
          end
        end
        tws_pkg::TWS_WAIT:
        begin
          if (clear_flag)
          begin
            if (c_q.status == tws_pkg::TWS_ST_DATA_NAK ||
                c_q.status == tws_pkg::TWS_ST_LAST_ACK)
              c_d.st = tws_pkg::TWS_IDLE;                                // [R12]
            else
            begin
              c_d.st      = tws_pkg::TWS_SEND;                           // [R06]
              c_d.shift   = c_q.data;
              c_d.cnt     = 4'h0;
              c_d.last    = ~acc.wdat[tws_pkg::TWS_B_ACK];               // [R07]
              c_d.sda_low = ~c_q.data[7];
              c_d.slept   = 1'b0;                                        // [R17]
            end
          end
        end
        tws_pkg::TWS_SEND:
        begin
          if (line.scl_fall)
          begin
            if (c_q.cnt == 4'h7)
            begin
              c_d.sda_low = 1'b0;
              c_d.st      = tws_pkg::TWS_GET_ACK;
            end
            else
            begin
              c_d.shift   = {c_q.shift[6:0], 1'b1};
              c_d.sda_low = ~c_q.shift[6];
              c_d.cnt     = c_q.cnt + 4'h1;
            end
          end
        end
        tws_pkg::TWS_GET_ACK:
        begin
          if (line.scl_rise)
          begin
            c_d.st   = tws_pkg::TWS_WAIT;
            c_d.hold = 1'b1;
            c_d.ctrl[tws_pkg::TWS_B_FLAG] = 1'b1;
            if (line.sda)
              c_d.status = tws_pkg::TWS_ST_DATA_NAK;                     // [R09]
            else if (c_q.last)
              c_d.status = tws_pkg::TWS_ST_LAST_ACK;                     // [R10]
            else
              c_d.status = tws_pkg::TWS_ST_DATA_ACK;                     // [R08]
          end
        end
        default:
          c_d.st = tws_pkg::TWS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c_q            <= '0;
      c_q.st         <= tws_pkg::TWS_IDLE;
      c_q.own        <= tws_pkg::TWS_OWN_RST;
      c_q.ctrl       <= tws_pkg::TWS_CTRL_RST;
      c_q.status     <= tws_pkg::TWS_ST_NONE;
      c_q.data       <= tws_pkg::TWS_DATA_RST;
      c_q.shift      <= tws_pkg::TWS_DATA_RST;
    end
    else
      c_q <= c_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // open drain: enable low pulls line low
  assign sda_o           = 1'b0;
  assign sda_oe_n_o      = ~c_q.sda_low;                                 // [R11]
  assign scl_o           = 1'b0;
  assign scl_oe_n_o      = ~(c_q.hold && !line.scl);                     // [R16]
  assign wake_o          = c_q.wake;                                     // [R15]
  assign irq_o           = flag & c_q.ctrl[tws_pkg::TWS_B_IRQEN];        // [R20]
  assign begin_pending_o = c_q.begin_pend;                               // [R13]
endmodule // tws_slave_tx

// >>> tws_slave_tx_properties.sv
`timescale 1ns/100ps
module tws_slave_tx_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic scl_i,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic sleep_i,
  input wire logic wake_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ack;
  assign wr_ack = ack_o & we_i;
  ////////////////////////////////////////////////////////////
  property p_ack_resp;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("bus not answered");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_irq_fall;
    $fell(irq_o) |-> $past(wr_ack) || $past(wr_ack, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell w/o write");
  property p_irq_rise;
    $rose(irq_o) |-> ##[0:30] !scl_oe_n_o;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq w/o stretch");
  property p_wake_rise;
    $rose(wake_o) |-> $past(sleep_i);
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("wake w/o sleep");
  property p_wake_fall;
    $fell(wake_o) |-> $past(wr_ack) || $past(wr_ack, 2);
  endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("wake fell w/o write");
  property p_scl_rel;
    $rose(scl_oe_n_o) |-> $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3);
  endproperty
  a_scl_rel: assert property (p_scl_rel) else $error("clock freed w/o write");
  property p_sda_move;
    $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_sda_move: assert property (p_sda_move) else $error("data moved, clock high");
endmodule // tws_slave_tx_props
bind tws_slave_tx tws_slave_tx_props i_tws_slave_tx_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .ack_o(ack_o), .scl_i(scl_i), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o),
  .sleep_i(sleep_i), .wake_o(wake_o), .irq_o(irq_o));

// >>> tws_master_model.sv
`timescale 1ns/100ps
module tws_master_model (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      tmo_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    tmo_o = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one bit, waits out clock stretching
  task automatic bit_io(input logic b, output logic s);
    int i;
    gap(4);
    sda_o <= b;
    gap(4);
    scl_o <= 1'b1;
    for (i = 0; i < 2000 && scl_i !== 1'b1; i++) @(posedge clk_i);
    if (i == 2000) tmo_o <= 1'b1;
    gap(8);
    s = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q,
                       output logic a);
    for (int j = 7; j >= 0; j--) bit_io(d[j], q[j]);
    bit_io(ab, a);
  endtask
  task automatic start;
    gap(8);
    sda_o <= 1'b0;
    gap(8);
    scl_o <= 1'b0;
  endtask
  task automatic stop;
    gap(4);
    sda_o <= 1'b0;
    gap(4);
    scl_o <= 1'b1;
    gap(8);
    sda_o <= 1'b1;
    gap(8);
  endtask
endmodule // tws_master_model

// >>> tb_tws_slave_tx.sv
`timescale 1ns/100ps
module tb_tws_slave_tx;
  localparam logic [3:0] A_O = tws_pkg::TWS_ADR_OWN;
  localparam logic [3:0] A_C = tws_pkg::TWS_ADR_CTRL;
  localparam logic [3:0] A_S = tws_pkg::TWS_ADR_STATUS;
  localparam logic [3:0] A_D = tws_pkg::TWS_ADR_DATA;
  logic        clk_i, rst_i, cyc, stb, we, sleep, arb, m_scl, m_sda, k, tmo;
  logic        ack, c_oe_n, d_oe_n, c_o, d_o, wake, irq, bgn;
  logic [3:0]  adr;
  logic [31:0] dw, dr;
  logic [7:0]  q, oa;
  wire         scl = m_scl & (c_oe_n | c_o);
  wire         sda = m_sda & (d_oe_n | d_o);
  int          err_count = 0;
  int          n_tests = 0;
  tws_slave_tx i_tws_slave_tx (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dw), .dat_o(dr), .ack_o(ack),
    .scl_i(scl), .scl_o(c_o), .scl_oe_n_o(c_oe_n), .sda_i(sda), .sda_o(d_o),
    .sda_oe_n_o(d_oe_n), .sleep_i(sleep), .arb_lost_i(arb), .wake_o(wake),
    .irq_o(irq), .begin_pending_o(bgn));
  tws_master_model i_tws_master_model (.clk_i(clk_i), .scl_i(scl), .sda_i(sda),
    .scl_o(m_scl), .sda_o(m_sda), .tmo_o(tmo));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    {cyc, stb, we, adr, dw} <= {2'b11, w, a, 24'h0, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
    if (i == 20) chk("bus timeout", 8'h1, 8'h0);
    if (i == 20) close_out();
    q = dr[7:0];
    {cyc, stb} <= 2'b00;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, q, e);
  endtask
  task automatic wirq;
    int i;
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk_i);
    if (i == 100) chk("irq timeout", 8'h1, 8'h0);
    if (i == 100) close_out();
  endtask
  task automatic addr(input logic [7:0] a);
    i_tws_master_model.start();
    i_tws_master_model.xbyte(a, 1'b1, q, k);
  endtask
  // ml: master answer to the final byte, 1 = not-acknowledge
  task automatic sess(input logic [7:0] a, input int n, input logic ml, input logic [7:0] s0);
    logic [7:0] d;
    addr(a);
    chk("address ack", k, 1'b0);
    wirq();
    if (sleep) chk("wake", wake, 1'b1);
    sleep <= 1'b0;
    chk("stretch", scl, 1'b0);
    rchk("status", A_S, s0);
    wb(1'b1, A_C, 8'h45);
    chk("flag kept", irq, 1'b1);
    wb(1'b1, A_C, 8'h44);
    chk("irq masked", irq, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      wb(1'b1, A_D, d);
      wb(1'b1, A_C, (i == n - 1) ? 8'h85 : 8'hc5);
      i_tws_master_model.xbyte(8'hff, (i == n - 1) ? ml : 1'b0, q, k);
      chk("data byte", q, d);
      wirq();
      rchk("status", A_S, (i < n - 1) ? 8'hb8 : (ml ? 8'hc0 : 8'hc8));
    end
    wb(1'b1, A_C, 8'he5);
    chk("begin pending", bgn, 1'b1);
    rchk("status idle", A_S, tws_pkg::TWS_ST_NONE);
    if (!ml) i_tws_master_model.xbyte(8'hff, 1'b1, q, k);
    if (!ml) chk("ignored", q, 8'hff);
    i_tws_master_model.stop();
    chk("begin served", bgn, 1'b0);
    $display("session %h done", a);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, sleep, arb, adr, dw} = '0;
    void'($urandom(32'ha74709f8));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk("own reset", A_O, tws_pkg::TWS_OWN_RST);
    rchk("control reset", A_C, tws_pkg::TWS_CTRL_RST);
    rchk("status reset", A_S, tws_pkg::TWS_ST_NONE);
    rchk("data reset", A_D, tws_pkg::TWS_DATA_RST);
    rchk("unmapped", 4'h2, 8'h00);
    $display("register test done");
    oa = {7'($urandom_range(126, 2)), 1'b1};
    wb(1'b1, A_O, oa);
    wb(1'b1, A_C, 8'h45);
    addr(oa ^ 8'h02);
    chk("foreign nack", k, 1'b1);
    i_tws_master_model.stop();
    sess(oa, $urandom_range(4, 2), 1'b1, 8'ha8);
    sess(oa, 1, 1'b0, 8'ha8);
    sess(8'h01, 1, 1'b1, 8'ha8);
    wb(1'b1, A_O, oa & 8'hfe);
    addr(8'h01);
    chk("broadcast off", k, 1'b1);
    i_tws_master_model.stop();
    wb(1'b1, A_C, 8'h05);
    addr(oa);
    chk("ack disabled", k, 1'b1);
    i_tws_master_model.stop();
    wb(1'b1, A_C, 8'h45);
    arb <= 1'b1;
    @(posedge clk_i);
    arb <= 1'b0;
    sess(oa, 2, 1'b1, 8'hb0);
    sleep <= 1'b1;
    sess(oa, 1, 1'b1, 8'ha8);
    chk("master timeout", tmo, 1'b0);
    close_out();
  end
endmodule // tb_tws_slave_tx
